/* hw/sdimb_defines.svh */
`ifndef SDIMB_DEFINES_SVH
`define SDIMB_DEFINES_SVH

// array geometry of the 16-bit variant
`define SDIMB_COL_W        9
`define SDIMB_ROW_W        12
`define SDIMB_DQ_W         16
// synchronised pin bundle layout
`define SDIMB_PIN_W        36
`define SDIMB_PIN_ADDR     16
`define SDIMB_PIN_BA       28
`define SDIMB_PIN_DQM      30
`define SDIMB_PIN_WE       31
`define SDIMB_PIN_CS       34
`define SDIMB_PIN_CKE      35
// command codes on {row strobe, column strobe, write enable}, low active
`define SDIMB_CMD_LMR      3'h0
`define SDIMB_CMD_REF      3'h1
`define SDIMB_CMD_PRE      3'h2
`define SDIMB_CMD_ACT      3'h3
`define SDIMB_CMD_WR       3'h4
`define SDIMB_CMD_RD       3'h5
`define SDIMB_CMD_BSTOP    3'h6
// operating_mode_setup fields
`define SDIMB_BL_LSB       0
`define SDIMB_BL_MSB       2
`define SDIMB_BT_BIT       3
`define SDIMB_LAT_LSB      4
`define SDIMB_LAT_MSB      6
`define SDIMB_WBM_BIT      9
`define SDIMB_BL_PAGE      3'h7
`define SDIMB_LAT3         3'h3
`define SDIMB_MODE_RST     12'h000
`define SDIMB_PRE_ALL_BIT  10
`define SDIMB_REF_MIN      2'h2
// access record {bank, row, col, mask, data} and its queue depth
`define SDIMB_ACC_W        40
`define SDIMB_FIFO_DEPTH   8

`endif

/* hw/sdimb_pkg.sv */
package sdimb_pkg;

	// power-up sequence tracking, gray along the path
	typedef enum logic [1:0] {
		SDIMB_POWER      = 2'h0,
		SDIMB_PRECHARGED = 2'h1,
		SDIMB_REFRESHED  = 2'h3,
		SDIMB_READY      = 2'h2
	} sdimb_init_e;

	typedef struct packed {
		logic [35:0]       pin1;
		logic [35:0]       pin2;
		logic [2:0]        sdc;
		logic [11:0]       mode;
		sdimb_init_e       init;
		logic [1:0]        ref_cnt;
		logic              mode_set;
		logic [3:0][11:0]  open_row;
		logic              bst_act;
		logic              bst_wr;
		logic [1:0]        bst_bank;
		logic [8:0]        bst_start;
		logic [8:0]        bst_idx;
		logic              rd_req;
		logic [1:0]        rd_bank;
		logic [11:0]       rd_row;
		logic [8:0]        rd_col;
		logic [1:0]        pv;
		logic [1:0][15:0]  pd;
		logic [15:0]       dq_out;
		logic              dq_oe;
		logic              wr_drop;
	} sdimb_state_s;

endpackage : sdimb_pkg

/* hw/sdimb_top.sv */
`timescale 1ns/10ps
`include "sdimb_defines.svh"
// Summary of operation
// - sample all pins on rising link clock
// - four banks, 4096 rows, 512 16-bit columns
// - row-open command latches row per bank
// - read/write low address bits give start column
// - mode setup held until next mode program
// - mode fields: length, order, latency, mode, write
// - lengths 1/2/4/8 both orders, page sequential
// - arbitrary length via page burst and stop
// - fixed bursts wrap inside aligned column block
// - page burst steps one column, wraps page
// - sequential adds index, interleaved xors index
// - read latency two or three clocks
// - drive from edge n+m-1, valid by n+m
// - deselected edge is a no-operation
// - write burst bit set gives single writes

////////////////////////////////////////////////////////////////////////////////
module sdimb_fifo
#(
	parameter int W = `SDIMB_ACC_W,
	parameter int D = `SDIMB_FIFO_DEPTH
)
(
	input  wire logic          core_clk,
	input  wire logic          rstn,
	input  wire logic          ce,
	input  wire logic          in_valid,
	output logic               in_ready,
	input  wire logic [W-1:0]  in_data,
	output logic               out_valid,
	input  wire logic          out_ready,
	output logic [W-1:0]       out_data
);
	localparam int AW = $clog2(D);
	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW-1:0]       wp;
		logic [AW-1:0]       rp;
		logic [AW:0]         cnt;
		logic                ne;
		logic                nf;
	} sdimb_fifo_s;
	sdimb_fifo_s st;
	sdimb_fifo_s next_st;
	logic        push;
	logic        pop;

	// pointer and count update, flags registered
	always_comb
	begin
		next_st = st;
		push    = ce && in_valid && st.nf;
		pop     = ce && out_ready && st.ne;
		if (push)
		begin
			next_st.mem[st.wp] = in_data;
			next_st.wp         = st.wp + 1'h1;
		end
		if (pop)
			next_st.rp = st.rp + 1'h1;
		next_st.cnt = st.cnt + {{AW{1'h0}}, push} - {{AW{1'h0}}, pop};
		next_st.ne  = next_st.cnt != '0;
		next_st.nf  = next_st.cnt != (AW+1)'(D);
	end

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			st <= '{mem: '0, wp: '0, rp: '0, cnt: '0, ne: 1'h0, nf: 1'h1};
		else
			st <= next_st;
	end

	assign in_ready  = st.nf;
	assign out_valid = st.ne;
	assign out_data  = st.mem[st.rp];
endmodule : sdimb_fifo

////////////////////////////////////////////////////////////////////////////////
module sdimb_top
(
	input  wire logic          core_clk,
	input  wire logic          rstn,
	input  wire logic          ce,
	input  wire logic          sd_clk,
	input  wire logic          cke,
	input  wire logic          cs_n,
	input  wire logic          ras_n,
	input  wire logic          cas_n,
	input  wire logic          we_n,
	input  wire logic          bank_select_low,
	input  wire logic          bank_select_high,
	input  wire logic [11:0]   addr,
	input  wire logic          dqm,
	input  wire logic [15:0]   dq_in,
	output logic [15:0]        dq_out,
	output logic               dq_oe,
	output logic               rd_req,
	output logic [1:0]         rd_bank,
	output logic [11:0]        rd_row,
	output logic [8:0]         rd_col,
	input  wire logic [15:0]   rd_data,
	output logic               acc_valid,
	input  wire logic          acc_ready,
	output logic [39:0]        acc_data,
	output logic [11:0]        operating_mode_setup,
	output logic               init_ready,
	output logic               wr_overrun
);
	sdimb_pkg::sdimb_state_s st;
	sdimb_pkg::sdimb_state_s next_st;
	logic        sd_edge;
	logic        cmd_ok;
	logic [2:0]  cmd;
	logic [11:0] addr_s;
	logic [1:0]  ba_s;
	logic [2:0]  bl;
	logic        page;
	logic        lat3;
	logic [8:0]  bl_mask;
	logic [8:0]  cont_col;
	logic        push_v;
	logic        push_rdy;
	logic [39:0] push_d;
	logic        el_v;
	logic        el_wr;
	logic [1:0]  el_bank;
	logic [8:0]  el_col;

	// decoded view of the synchronised pins and the mode setup
	assign sd_edge  = st.sdc[1] && !st.sdc[2];
	assign cmd_ok   = st.pin2[`SDIMB_PIN_CKE] && !st.pin2[`SDIMB_PIN_CS];
	assign cmd      = st.pin2[`SDIMB_PIN_WE+2:`SDIMB_PIN_WE];
	assign addr_s   = st.pin2[`SDIMB_PIN_ADDR+11:`SDIMB_PIN_ADDR];
	assign ba_s     = st.pin2[`SDIMB_PIN_BA+1:`SDIMB_PIN_BA];
	assign bl       = st.mode[`SDIMB_BL_MSB:`SDIMB_BL_LSB];
	assign page     = bl == `SDIMB_BL_PAGE;
	assign lat3     = st.mode[`SDIMB_LAT_MSB:`SDIMB_LAT_LSB] == `SDIMB_LAT3;
	assign bl_mask  = (bl == 3'h1) ? 9'h001 : (bl == 3'h2) ? 9'h003 :
		(bl == 3'h3) ? 9'h007 : 9'h000;
	// next column of a running burst
	assign cont_col = page ? st.bst_start + st.bst_idx :
		(st.bst_start & ~bl_mask) | (bl_mask & (st.mode[`SDIMB_BT_BIT] ?
		(st.bst_start ^ st.bst_idx) : (st.bst_start + st.bst_idx)));

	// whole next state of the device
	always_comb
	begin
		next_st = st;
		push_v  = 1'h0;
		push_d  = '0;
		el_v    = 1'h0;
		el_wr   = st.bst_wr;
		el_bank = st.bst_bank;
		el_col  = cont_col;
		if (ce)
		begin
			next_st.sdc    = {st.sdc[1:0], sd_clk};
			next_st.pin1   = {cke, cs_n, ras_n, cas_n, we_n, dqm, bank_select_high,
				bank_select_low, addr, dq_in};
			next_st.pin2   = st.pin1;
			next_st.rd_req = 1'h0;
			// read data is taken in the same cycle as the request
			if (st.rd_req)
			begin
				next_st.pv[0] = 1'h1;
				next_st.pd[0] = rd_data;
			end
			if (sd_edge)
			begin
				// output stage: one or two link edges behind the access
				next_st.dq_oe  = lat3 ? st.pv[1] : st.pv[0];
				next_st.dq_out = lat3 ? st.pd[1] : st.pd[0];
				next_st.pv     = {st.pv[0], 1'h0};
				next_st.pd[1]  = st.pd[0];
				// command decode
				if (cmd_ok)
				begin
					case (cmd)
						`SDIMB_CMD_RD, `SDIMB_CMD_WR:
						begin
							el_v              = 1'h1;
							el_wr             = cmd == `SDIMB_CMD_WR;
							el_bank           = ba_s;
							el_col            = addr_s[8:0];
							next_st.bst_start = addr_s[8:0];
							next_st.bst_bank  = ba_s;
							next_st.bst_wr    = el_wr;
							next_st.bst_idx   = 9'h001;
							next_st.bst_act   = (page || bl_mask != 9'h000) &&
								!(el_wr && st.mode[`SDIMB_WBM_BIT]);
						end
						`SDIMB_CMD_BSTOP:
							next_st.bst_act = 1'h0;
						`SDIMB_CMD_PRE:
						begin
							next_st.bst_act = 1'h0;
							if (addr_s[`SDIMB_PRE_ALL_BIT] && st.init == sdimb_pkg::SDIMB_POWER)
								next_st.init = sdimb_pkg::SDIMB_PRECHARGED;
						end
						`SDIMB_CMD_ACT:
							next_st.open_row[ba_s] = addr_s;
						`SDIMB_CMD_REF:
							if (st.init != sdimb_pkg::SDIMB_POWER && st.ref_cnt != `SDIMB_REF_MIN)
								next_st.ref_cnt = st.ref_cnt + 2'h1;
						`SDIMB_CMD_LMR:
						begin
							next_st.mode     = addr_s;
							next_st.mode_set = 1'h1;
						end
						default:
						begin
						end
					endcase
				end
				// running burst continues while the clock is not gated
				if (!el_v && st.bst_act && st.pin2[`SDIMB_PIN_CKE] &&
					!(cmd_ok && (cmd == `SDIMB_CMD_BSTOP || cmd == `SDIMB_CMD_PRE)))
				begin
					el_v            = 1'h1;
					next_st.bst_idx = st.bst_idx + 9'h001;
					next_st.bst_act = page || (st.bst_idx < bl_mask);
				end
				// dispatch one access
				if (el_v && !el_wr)
				begin
					next_st.rd_req  = 1'h1;
					next_st.rd_bank = el_bank;
					next_st.rd_row  = st.open_row[el_bank];
					next_st.rd_col  = el_col;
				end
				if (el_v && el_wr)
				begin
					push_v = 1'h1;
					push_d = {el_bank, st.open_row[el_bank], el_col,
						st.pin2[`SDIMB_PIN_DQM], st.pin2[15:0]};
					if (!push_rdy)
						next_st.wr_drop = 1'h1;
				end
			end
			// power-up progress, mode may come before or after the refreshes
			case (st.init)
				sdimb_pkg::SDIMB_POWER:
				begin
				end
				sdimb_pkg::SDIMB_PRECHARGED:
					if (next_st.ref_cnt == `SDIMB_REF_MIN)
						next_st.init = sdimb_pkg::SDIMB_REFRESHED;
				sdimb_pkg::SDIMB_REFRESHED:
					if (next_st.mode_set)
						next_st.init = sdimb_pkg::SDIMB_READY;
				sdimb_pkg::SDIMB_READY:
				begin
				end
				default:
					next_st.init = sdimb_pkg::SDIMB_POWER;
			endcase
		end
	end

	// state register
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			st <= '0;
		else
			st <= next_st;
	end

	// write access queue toward the storage side
	sdimb_fifo #(
		.W(`SDIMB_ACC_W),
		.D(`SDIMB_FIFO_DEPTH)
	) sdimb_fifo_i (
		.core_clk  (core_clk),
		.rstn      (rstn),
		.ce        (ce),
		.in_valid  (push_v),
		.in_ready  (push_rdy),
		.in_data   (push_d),
		.out_valid (acc_valid),
		.out_ready (acc_ready),
		.out_data  (acc_data)
	);

	assign dq_out               = st.dq_out;
	assign dq_oe                = st.dq_oe;
	assign rd_req               = st.rd_req;
	assign rd_bank              = st.rd_bank;
	assign rd_row               = st.rd_row;
	assign rd_col               = st.rd_col;
	assign operating_mode_setup = st.mode;
	assign init_ready           = st.init == sdimb_pkg::SDIMB_READY;
	assign wr_overrun           = st.wr_drop;

	////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);

	AST_EDGE_ONLY: assert property (!sd_edge |=> $stable(st.open_row) && $stable(st.bst_idx))
		else $error("state moved without a link clock edge");
	AST_ROW_OPEN: assert property (ce && sd_edge && cmd_ok && cmd == `SDIMB_CMD_ACT
		|=> st.open_row[$past(ba_s)] == $past(addr_s))
		else $error("row not latched for bank");
	AST_ROW_OUT: assert property (st.rd_req |-> st.rd_row == st.open_row[st.rd_bank])
		else $error("read row differs from open row");
	AST_START_COL: assert property (ce && sd_edge && cmd_ok && cmd == `SDIMB_CMD_RD
		|=> st.rd_req && st.rd_col == $past(addr_s[8:0]))
		else $error("read did not start at given column");
	AST_MODE_LOAD: assert property (ce && sd_edge && cmd_ok && cmd == `SDIMB_CMD_LMR
		|=> operating_mode_setup == $past(addr_s))
		else $error("mode setup not loaded");
	AST_MODE_HOLD: assert property (!(ce && sd_edge && cmd_ok && cmd == `SDIMB_CMD_LMR)
		|=> $stable(st.mode))
		else $error("mode setup changed without program");
	AST_NOP_DESEL: assert property (ce && sd_edge && !cmd_ok && !st.bst_act
		|=> !st.rd_req ##1 !st.rd_req)
		else $error("deselected edge caused an access");
	AST_BURST_MAX: assert property (st.bst_act && !page |-> st.bst_idx <= bl_mask)
		else $error("fixed burst ran past its length");
	AST_BLOCK_WRAP: assert property (st.rd_req && !page
		|-> ((st.rd_col ^ st.bst_start) & ~bl_mask) == 9'h000)
		else $error("burst left its column block");
	AST_ORDER: assert property (st.rd_req && !page && !st.bst_wr
		|-> (st.rd_col & bl_mask) == (bl_mask & (st.mode[`SDIMB_BT_BIT] ?
		(st.bst_start ^ (st.bst_idx - 9'h001)) : (st.bst_start + st.bst_idx - 9'h001))))
		else $error("burst order wrong");
	AST_PAGE_STEP: assert property (st.rd_req && page && !st.bst_wr
		|-> st.rd_col == st.bst_start + st.bst_idx - 9'h001)
		else $error("page burst did not step by one");
	AST_LAT_OUT: assert property (ce && sd_edge && st.pv[lat3]
		|=> st.dq_oe && st.dq_out == $past(st.pd[lat3]))
		else $error("read data not driven at latency");
	AST_RD_CAPTURE: assert property (ce && st.rd_req |=> st.pv[0] && st.pd[0] == $past(rd_data))
		else $error("read data not captured");
	AST_WR_SINGLE: assert property (ce && sd_edge && cmd_ok && cmd == `SDIMB_CMD_WR
		&& st.mode[`SDIMB_WBM_BIT] |=> !st.bst_act)
		else $error("single write kept bursting");

	COV_LAT3_READ: cover property (lat3 && ce && sd_edge && st.pv[1] ##1 st.dq_oe);
	COV_PAGE_BURST: cover property (page && st.rd_req && st.bst_idx == 9'h008);
	COV_INIT_DONE: cover property (!init_ready ##1 init_ready);
	COV_WQ_FULL: cover property (!push_rdy && acc_valid);
endmodule : sdimb_top

/* tb/sdimb_ctrl_model.sv */
`timescale 1ns/10ps
// controller side of the link: free clock, one command per rising edge
module sdimb_ctrl_model
(
	output logic        sd_clk,
	output logic        cke,
	output logic        cs_n,
	output logic        ras_n,
	output logic        cas_n,
	output logic        we_n,
	output logic [1:0]  ba,
	output logic [11:0] addr,
	output logic        dqm,
	output logic [15:0] dq
);
	// clock runs free, pins start deselected with mask and clock gate high
	initial
	begin
		{cke, cs_n, ras_n, cas_n, we_n, dqm} = 6'h3F;
		ba = 2'h0;
		addr = 12'h000;
		dq = 16'h0000;
		sd_clk = 1'b0;
		forever #24 sd_clk = ~sd_clk;
	end
	// pins change at the falling edge and hold over the next rising edge
	task automatic step(input logic [3:0] c, input logic [1:0] b, input logic [11:0] a,
		input logic m, input logic [15:0] d, input logic k);
		@(negedge sd_clk);
		cke = k;
		{cs_n, ras_n, cas_n, we_n} = c;
		ba = b;
		addr = a;
		dqm = m;
		dq = d;
		@(posedge sd_clk);
		#1;
	endtask : step
endmodule : sdimb_ctrl_model

/* tb/sdram_init_mode_burst_tb_top.sv */
`timescale 1ns/10ps
`include "sdimb_defines.svh"
// bench: commands through the controller model, results matched from queues
module sdram_init_mode_burst_tb_top;
	logic        core_clk, rstn, ce, acc_ready, stall, p_oe, wm, gate;
	logic        sd_clk, cke, cs_n, ras_n, cas_n, we_n, dqm, dq_oe, rd_req;
	logic        acc_valid, init_ready, wr_overrun;
	logic [1:0]  ba, rd_bank;
	logic [11:0] addr, rd_row, operating_mode_setup;
	logic [8:0]  rd_col;
	logic [15:0] dq_in, dq_out, rd_data, p_dq, wd;
	logic [39:0] acc_data;
	logic [11:0] rows [4];
	logic [63:0] q_rd [$], q_dq [$], q_acc [$];
	int          n_mismatch, samples_checked, ecnt;

	sdimb_ctrl_model sdimb_ctrl_model_i
	(
		.sd_clk(sd_clk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
		.we_n(we_n), .ba(ba), .addr(addr), .dqm(dqm), .dq(dq_in)
	);
	sdimb_top sdimb_top_i
	(
		.core_clk(core_clk), .rstn(rstn), .ce(ce), .sd_clk(sd_clk), .cke(cke),
		.cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
		.bank_select_low(ba[0]), .bank_select_high(ba[1]), .addr(addr), .dqm(dqm),
		.dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .rd_req(rd_req),
		.rd_bank(rd_bank), .rd_row(rd_row), .rd_col(rd_col), .rd_data(rd_data),
		.acc_valid(acc_valid), .acc_ready(acc_ready), .acc_data(acc_data),
		.operating_mode_setup(operating_mode_setup), .init_ready(init_ready),
		.wr_overrun(wr_overrun)
	);
	////////////////////////////////////////
	// clock, storage answer and link edge count
	initial
	begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	assign rd_data = {rd_bank, rd_col, rd_row[4:0]};
	always @(posedge sd_clk) ecnt <= ecnt + 1;
	always @(posedge core_clk) acc_ready <= #1 !stall && 1'($urandom);

	task automatic cmp(input logic [63:0] g, input logic [63:0] e);
		samples_checked++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : cmp
	task automatic pop(ref logic [63:0] q [$], input logic [63:0] g, input bit lax);
		if (q.size() > 0)
			cmp(g, q.pop_front());
		else if (!lax)
			cmp(g, 64'h0 - 64'h1);
	endtask : pop
	// outputs matched against the oldest note of each kind
	always @(posedge core_clk)
	begin
		if (rd_req)
			pop(q_rd, {41'h0, rd_bank, rd_row, rd_col}, 1'b0);
		if (dq_oe && (!p_oe || dq_out !== p_dq))
			pop(q_dq, {32'(ecnt), 16'h0, dq_out}, 1'b0);
		if (acc_valid && acc_ready && ce)
			pop(q_acc, {24'h0, acc_data}, 1'b0);
		p_oe <= dq_oe;
		p_dq <= dq_out;
	end
	////////////////////////////////////////
	function automatic logic [8:0] col_at(input logic [8:0] s, input logic [2:0] bl,
		input logic bt, input int i);
		logic [8:0] k;
		k = (bl == `SDIMB_BL_PAGE) ? 9'h1FF : (9'h1 << bl) - 9'h1;
		return (s & ~k) | ((bt ? (s ^ 9'(i)) : (s + 9'(i))) & k);
	endfunction : col_at
	task automatic go(input logic [3:0] c, input logic [1:0] b, input logic [11:0] a);
		wd = 16'($urandom);
		wm = 1'($urandom);
		sdimb_ctrl_model_i.step(c, b, a, wm, wd, !gate);
	endtask : go
	task automatic nop(input int k);
		repeat (k) go(4'h7, 2'h0, 12'h000);
	endtask : nop
	task automatic setmode(input logic [11:0] v, input logic pre);
		if (pre)
			go({1'b0, `SDIMB_CMD_PRE}, 2'h0, 12'h400);
		go({1'b0, `SDIMB_CMD_LMR}, 2'h0, v);
		nop(2);
		cmp(operating_mode_setup, v);
	endtask : setmode
	task automatic init(input logic early);
		repeat (2084)
			sdimb_ctrl_model_i.step(4'h7, 2'h0, 12'h000, 1'b1, 16'h0000, 1'b1);
		if (early)
			setmode(12'h032, 1'b1);
		else
			go({1'b0, `SDIMB_CMD_PRE}, 2'h0, 12'h400);
		go({1'b0, `SDIMB_CMD_REF}, 2'h0, 12'h000);
		nop(1);
		cmp(init_ready, 1'b0);
		go({1'b0, `SDIMB_CMD_REF}, 2'h0, 12'h000);
		nop(1);
		cmp(init_ready, early);
		if (!early)
			setmode(12'h032, 1'b0);
		cmp(init_ready, 1'b1);
	endtask : init
	// one burst: read expectations noted before each command or data edge is sent, write expectations after it
	task automatic acc(input logic w, input logic [11:0] v, input logic [8:0] s, input int k,
		input logic stop);
		logic [1:0] b;
		logic [8:0] c;
		int         m;
		int         n;
		b = 2'($urandom);
		m = (v[6:4] == `SDIMB_LAT3) ? 3 : 2;
		setmode(v, 1'b1);
		go({1'b0, `SDIMB_CMD_ACT}, b, rows[b]);
		nop(2);
		n = ecnt + 1;
		for (int i = 0; i < k; i++)
		begin
			c = col_at(s, v[2:0], v[3], i);
			if (!w)
				q_rd.push_back({41'h0, b, rows[b], c});
			if (!w)
				q_dq.push_back({32'(n + m - 1 + i), 16'h0, b, c, rows[b][4:0]});
			go(i > 0 ? 4'h7 : {1'b0, w ? `SDIMB_CMD_WR : `SDIMB_CMD_RD}, b, {3'h0, s});
			if (w && q_acc.size() < `SDIMB_FIFO_DEPTH)
				q_acc.push_back({24'h0, b, rows[b], c, wm, wd});
		end
		if (stop)
			go({1'b0, `SDIMB_CMD_BSTOP}, 2'h0, 12'h000);
		nop(m + 3);
	endtask : acc
	task automatic complete_run();
		$display("checked=%0d mismatches=%0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : complete_run
	////////////////////////////////////////
	// main sequence
	initial
	begin
		void'($urandom(32'h8589));
		{rstn, stall, gate} = 3'h0;
		ce = 1'b1;
		foreach (rows[i])
			rows[i] = 12'($urandom);
		repeat (4) @(posedge core_clk);
		cmp({operating_mode_setup, init_ready, acc_valid, dq_oe, wr_overrun}, 64'h0);
		#1 rstn = 1'b1;
		init(1'b0);
		go(4'h8, 2'h0, 12'h0FF);
		go({1'b1, `SDIMB_CMD_RD}, 2'h0, 12'h000);
		gate = 1'b1;
		go({1'b0, `SDIMB_CMD_RD}, 2'h0, 12'h000);
		gate = 1'b0;
		nop(1);
		cmp(operating_mode_setup, 12'h032);
		for (int i = 0; i < 16; i++)
			acc(1'b0, {5'h0, i[3] ? 3'h3 : 3'h2, i[2], 1'b0, i[1:0]}, 9'($urandom),
				1 << i[1:0], 1'b0);
		for (int i = 0; i < 2; i++)
			acc(1'b1, {2'h0, i[0], 9'h02A}, 9'($urandom), i ? 1 : 4, 1'b0);
		cmp(wr_overrun, 1'b0);
		acc(1'b0, 12'h037, 9'h1FC, 10, 1'b1);
		stall = 1'b1;
		acc(1'b1, 12'h037, 9'h1FD, 9, 1'b1);
		cmp({acc_valid, wr_overrun}, 2'h3);
		stall = 1'b0;
		for (int t = 0; t < 400 && q_acc.size() > 0; t++)
			@(posedge core_clk);
		repeat (3) @(posedge core_clk);
		cmp({acc_valid, 32'(q_acc.size() + q_rd.size() + q_dq.size())}, 64'h0);
		@(posedge core_clk);
		#1 rstn = 1'b0;
		@(posedge core_clk);
		cmp({operating_mode_setup, init_ready, wr_overrun}, 14'h0000);
		#1 rstn = 1'b1;
		init(1'b1);
		complete_run();
	end
endmodule : sdram_init_mode_burst_tb_top
